// ==== rtl/bcl_loader.sv ====
// boot configuration latch loader: four configuration bytes, applied at reset
// assumes the latch array keeps its contents across rst_i (nonvolatile model:
// only the power-on initial contents are the factory defaults)
//
// Operation
// R1 - four latch bytes applied on reset exit
// R2 - one two-bit drive mode per port
// R3 - drive codes: analog, digital, pull-up, pull-down
// R4 - bytes 0,1 hold port drive fields
// R5 - bytes 2,3 hold reset, debug, clock fields
// R6 - reset pin: 0 gpio, 1 external reset
// R7 - debug enable: 0 blocked, 1 allowed
// R8 - boot speed: 0 12 MHz, 1 48 MHz
// R9 - debug port: jtag5, jtag4, swd, off
// R10 - ecc enable: 1 ecc, 0 data storage
// R11 - four-bit clock phase delay field
// R12 - sample once at release, hold until reset
`timescale 1ns/1ps
`default_nettype none

module bcl_loader
  import bcl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // applied configuration
  output bcl_cfg_t         cfg_o,
  output logic             cfg_valid_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  // power-up value: factory default latch bytes, all else cleared; given at
  // the declaration so that the clocked process stays the only driver of r
  bcl_regs_t r = bcl_regs_t'({BCL_RST_BOOT_DBG, BCL_RST_RESET_DBG, BCL_RST_DRIVE_HIGH, BCL_RST_DRIVE_LOW,
                              {($bits(bcl_regs_t) - 32){1'b0}}});
  bcl_regs_t next_r;
  bcl_cfg_t  decoded;
  logic      req;
  logic [7:0] idx;
  logic [31:0] applied_word;

  // ****************************************************************
  // decode of latch bytes into configuration fields
  // ****************************************************************
  always_comb begin
    decoded = '0;
    // R2 one field per port
    // R4 ports 0..3 in byte 0, ports 4..7 in byte 1
    // R3 drive code passed unchanged
    for (int p = 0; p < BCL_NUM_PORTS / 2; p++) begin
      decoded.port_reset_drive[p]     = bcl_drive_t'(r.config_latch[0][2*p +: 2]);
      decoded.port_reset_drive[p + 4] = bcl_drive_t'(r.config_latch[1][2*p +: 2]);
    end
    // R5 byte 2 and byte 3 fields
    // R6 reset pin select
    decoded.reset_pin_select    = r.config_latch[2][BCL_POS_RESET_PIN];
    // R7 debug access enable
    decoded.debug_access_enable = r.config_latch[2][BCL_POS_DEBUG_EN];
    // R8 boot speed select
    decoded.boot_speed_select   = r.config_latch[3][BCL_POS_BOOT_SPEED];
    // R9 debug port select
    decoded.debug_port_select   = bcl_dbg_port_t'(r.config_latch[3][BCL_POS_DPS_LSB +: 2]);
    // R10 ecc area enable
    decoded.ecc_area_enable     = r.config_latch[3][BCL_POS_ECC_EN];
    // R11 phase delay field
    decoded.clock_phase_delay   = r.config_latch[3][BCL_POS_PHASE_LSB +: 4];
  end

  assign req = cyc_i & stb_i & ~r.ack;
  assign idx = {3'b000, adr_i[4:2]};
  assign applied_word = {16'h0000, r.cfg.port_reset_drive};

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_r       = r;
    next_r.ack   = req;   // one answer the cycle after the request, dropped the next cycle
    next_r.rdata = 32'h0000_0000;
    case (r.state)
      BCL_ST_RESET: begin
        next_r.state = BCL_ST_SAMPLE;
      end
      BCL_ST_SAMPLE: begin
        // R1 apply latches on reset exit
        // R12 sample once at release
        next_r.cfg   = decoded;
        next_r.state = BCL_ST_RUN;
      end
      BCL_ST_RUN: begin
        // R12 hold until next reset
        next_r.state = BCL_ST_RUN;
      end
      default: begin
        next_r.state = BCL_ST_RESET;
      end
    endcase
    if (req) begin
      if (we_i) begin
        // programming only changes the latch bytes, never cfg
        if (idx < 8'(BCL_LATCH_BYTES) && sel_i[0]) begin
          next_r.config_latch[idx[1:0]] = dat_i[7:0];
        end
      end else begin
        case (idx)
          BCL_IDX_DRIVE_LOW,
          BCL_IDX_DRIVE_HIGH,
          BCL_IDX_RESET_DBG,
          BCL_IDX_BOOT_DBG:   next_r.rdata = {24'h000000, r.config_latch[idx[1:0]]};
          BCL_IDX_APPLIED_LO: next_r.rdata = applied_word;
          BCL_IDX_APPLIED_HI: next_r.rdata = {21'h000000, r.cfg[10:0]};
          BCL_IDX_STATUS:     next_r.rdata = {31'h00000000, r.state == BCL_ST_RUN};
          default:            next_r.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // registers; latch bytes survive reset since they model nonvolatile cells
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.cfg   <= '0;
      r.state <= BCL_ST_RESET;
      r.ack   <= 1'b0;
      r.rdata <= 32'h0000_0000;
      r.config_latch <= r.config_latch;
    end else begin
      r <= next_r;
    end
  end

  assign dat_o       = r.rdata;
  assign ack_o       = r.ack;
  assign cfg_o       = r.cfg;
  assign cfg_valid_o = (r.state == BCL_ST_RUN);

endmodule

`default_nettype wire

// ==== inc/bcl_pkg.sv ====
// package for the boot configuration latch loader
// assumes a single 25 MHz clock domain and a classic wishbone register bus
package bcl_pkg;

  // ****************************************************************
  // register map: printed offsets 0..3 are indices, byte addr = 4*index
  // ****************************************************************
  localparam logic [7:0] BCL_IDX_DRIVE_LOW  = 8'h00;
  localparam logic [7:0] BCL_IDX_DRIVE_HIGH = 8'h01;
  localparam logic [7:0] BCL_IDX_RESET_DBG  = 8'h02;
  localparam logic [7:0] BCL_IDX_BOOT_DBG   = 8'h03;
  localparam logic [7:0] BCL_IDX_APPLIED_LO = 8'h04;
  localparam logic [7:0] BCL_IDX_APPLIED_HI = 8'h05;
  localparam logic [7:0] BCL_IDX_STATUS     = 8'h06;
  localparam int         BCL_NUM_REGS       = 7;
  localparam int         BCL_LATCH_BYTES    = 4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BCL_POS_RESET_PIN   = 7;
  localparam int BCL_POS_DEBUG_EN    = 6;
  localparam int BCL_POS_PHASE_LSB   = 4;
  localparam int BCL_POS_ECC_EN      = 3;
  localparam int BCL_POS_DPS_LSB     = 1;
  localparam int BCL_POS_BOOT_SPEED  = 0;
  localparam int BCL_NUM_PORTS       = 8;

  // ****************************************************************
  // factory default latch contents
  // ****************************************************************
  localparam logic [7:0] BCL_RST_DRIVE_LOW  = 8'h00;
  localparam logic [7:0] BCL_RST_DRIVE_HIGH = 8'h00;
  localparam logic [7:0] BCL_RST_RESET_DBG  = 8'h40;
  localparam logic [7:0] BCL_RST_BOOT_DBG   = 8'h0a;

  // reset drive mode encodings
  typedef enum logic [1:0] {
    BCL_DRV_HIZ_ANALOG  = 2'b00,
    BCL_DRV_HIZ_DIGITAL = 2'b01,
    BCL_DRV_PULL_UP     = 2'b10,
    BCL_DRV_PULL_DOWN   = 2'b11
  } bcl_drive_t;

  // debug port encodings
  typedef enum logic [1:0] {
    BCL_DBG_JTAG5 = 2'b00,
    BCL_DBG_JTAG4 = 2'b01,
    BCL_DBG_SWD   = 2'b10,
    BCL_DBG_OFF   = 2'b11
  } bcl_dbg_port_t;

  // applied configuration seen by the rest of the chip
  typedef struct packed {
    bcl_drive_t [BCL_NUM_PORTS-1:0] port_reset_drive;
    logic                           reset_pin_select;
    logic                           debug_access_enable;
    logic                           boot_speed_select;
    bcl_dbg_port_t                  debug_port_select;
    logic                           ecc_area_enable;
    logic [3:0]                     clock_phase_delay;
  } bcl_cfg_t;

  typedef enum logic [1:0] {
    BCL_ST_RESET   = 2'b00,
    BCL_ST_SAMPLE  = 2'b01,
    BCL_ST_RUN     = 2'b10
  } bcl_state_t;

  typedef struct packed {
    logic [BCL_LATCH_BYTES-1:0][7:0] config_latch;
    bcl_cfg_t                        cfg;
    bcl_state_t                      state;
    logic                            ack;
    logic [31:0]                     rdata;
  } bcl_regs_t;

endpackage

// ==== testbench/bcl_loader_properties.sv ====
// port checker for the boot configuration loader
// assumes one clock domain and the loader's one-cycle wishbone answer
`timescale 1ns/1ps
`default_nettype none
module bcl_loader_properties
  import bcl_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire bcl_cfg_t    cfg_o,
  input wire logic        cfg_valid_o
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  idle_zero_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  valid_rise_a: assert property ($fell(rst_i) |-> !cfg_valid_o ##[1:3] cfg_valid_o)
    else $error("config not applied");
  valid_stay_a: assert property (cfg_valid_o |=> cfg_valid_o)
    else $error("valid dropped");
  cfg_hold_a: assert property (cfg_valid_o |=> $stable(cfg_o))
    else $error("config changed");
  cfg_zero_a: assert property (!cfg_valid_o |-> cfg_o == '0)
    else $error("config before apply");
  drive_read_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == 5'h10
    |-> dat_o == {16'h0, cfg_o.port_reset_drive})
    else $error("drive readback");
  misc_read_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == 5'h14
    |-> dat_o == {21'h0, cfg_o[10:0]})
    else $error("field readback");
  status_read_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == 5'h18
    |-> dat_o == {31'h0, $past(cfg_valid_o)})
    else $error("status readback");
  // main scenarios reached
  cover property (ack_o && $past(we_i));
  cover property ($rose(cfg_valid_o));
  cover property (ack_o && $past(adr_i) == 5'h14);
endmodule
bind bcl_loader bcl_loader_properties u_prop (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .dat_o, .ack_o, .cfg_o, .cfg_valid_o);
`default_nettype wire

// ==== testbench/bcl_loader_tb.sv ====
// bench for the boot configuration loader
// assumes latch bytes survive rst_i and reads answer through wishbone
`timescale 1ns/1ps
`default_nettype none
module bcl_loader_tb
  import bcl_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0] sel_i = 4'h1;
  logic [4:0] adr_i = 5'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q, v, p;
  logic ack_o, cfg_valid_o;
  bcl_cfg_t cfg_o;
  int n_fail = 0, cmp_count = 0;
  logic [31:0] tab [4] = '{32'ha5801be4, 32'h5a40e41b, 32'hf9c000ff, 32'h0600ff00};
  bcl_loader dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .cfg_o(cfg_o), .cfg_valid_o(cfg_valid_o));
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  // ****************
  // helpers
  // ****************
  function automatic bcl_cfg_t ec(logic [31:0] b);
    ec = {b[15:0], b[23], b[22], b[24], b[26:25], b[27], b[31:28]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %0t seen %h want %h", $time, s, e);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rs();
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog: a hung handshake ends the run
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  // ****************
  // tests
  // ****************
  initial begin
    p = 32'h0a400000;
    rs();
    chk(cfg_o, ec(p));
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 5'(i * 4), 8'h0);
      chk(q, {24'h0, p[8*i+:8]});
    end
    // a write without the low byte lane is acked but leaves the latch alone
    sel_i <= 4'h0;
    bus(1'b1, 5'h0, 8'hff);
    sel_i <= 4'h1;
    bus(1'b0, 5'h0, 8'h0);
    chk(q, {24'h0, p[7:0]});
    // the table rows together set all drive and debug port codes across the run
    foreach (tab[k]) begin
      v = tab[k];
      for (int i = 0; i < 4; i++) bus(1'b1, 5'(i * 4), v[8*i+:8]);
      bus(1'b1, 5'h10, 8'hff);
      for (int i = 0; i < 4; i++) begin
        bus(1'b0, 5'(i * 4), 8'h0);
        chk(q, {24'h0, v[8*i+:8]});
      end
      chk(cfg_o, ec(p));
      rs();
      chk({31'h0, cfg_valid_o}, 32'h1);
      chk(cfg_o, ec(v));
      bus(1'b0, 5'h10, 8'h0);
      chk(q, {16'h0, v[15:0]});
      bus(1'b0, 5'h1c, 8'h0);
      chk(q, 32'h0);
      bus(1'b0, 5'h14, 8'h0);
      chk(q, {21'h0, v[0], v[23], v[22], v[24], v[26:25], v[27], v[31:28]});
      bus(1'b0, 5'h18, 8'h0);
      chk(q, 32'h1);
      p = v;
    end
    wrap_up();
  end
endmodule
`default_nettype wire
